// *** logic/rsmc_codec.sv ***
/*
 * Stream-mode coder/decoder: receives sub-carrier or BPSK streams into
 * FIFO bytes and serialises FIFO bytes into carrier modulation.
 * Assumes a register write port from the serial interface, a FIFO pop/push
 * side on this clock, and carrier and sub-carrier pins from the analog side.
 */
`timescale 1ns/1ps
`include "rsmc_regs.svh"

// Behaviour
// RULE_01: Sub-carrier receive supports fc/64 to fc/8.
// RULE_02: Sub-carrier reporting period two to eight periods.
// RULE_03: First carrier period: start event, first bit.
// RULE_04: Sub-carrier: bit 1 present, 0 absent.
// RULE_05: Sub-carrier ends after over eight empty periods.
// RULE_06: Sub mode scf 01b fc/32, scp 10b four.
// RULE_07: BPSK receive supports fc/16 to fc/4.
// RULE_08: BPSK reporting period one to eight periods.
// RULE_09: BPSK: initial phase 0, inverted phase 1.
// RULE_10: BPSK ends at first empty period.
// RULE_11: BPSK scf 01b fc/8, scp 01b two.
// RULE_12: Tx bit 0 unmodulated, 1 modulated.
// RULE_13: Tx bit period field, 000b is 128 cycles.
// RULE_14: Transmission starts only on transmit command.
// RULE_15: First bit in FIFO byte LSB.
// RULE_16: Controller selects stream mode and options first.
// RULE_17: All timing counted in carrier cycles.
// RULE_18: Pack bits, commit partial byte at end.
module rsmc_codec #(
    parameter int DET_EDGES = 2
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic reg_wr_i,
    input wire logic [5:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic carrier_i,
    input wire logic subcarrier_i,
    input wire logic tx_cmd_i,
    input wire logic tx_cmd_crc_i,
    input wire logic [7:0] tx_byte_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic mod_o,
    output logic tx_busy_o,
    output logic [7:0] rx_byte_o,
    output logic [3:0] rx_nbits_o,
    output logic rx_push_o,
    output logic rx_start_o,
    output logic rx_end_o
);
    if (DET_EDGES < 1 || DET_EDGES > 15) begin : g_bad_det
        $error("DET_EDGES must lie in 1..15");
    end

    localparam logic [3:0] DET_MIN = 4'(DET_EDGES);

    rsmc_pkg::rsmc_state_t state_ff;
    rsmc_pkg::rsmc_state_t nxt_state;

    logic car_tick;
    logic sc_edge;
    logic is_sub;
    logic is_bpsk;
    logic [1:0] scf;
    logic [1:0] scp_eff;
    logic [2:0] stx;
    logic [6:0] sub_len;
    logic [9:0] per_len;
    logic [7:0] tx_len;
    logic per_end;
    logic present;
    logic tx_go;

    always_comb begin
        car_tick = state_ff.car_sync[1] & ~state_ff.car_sync[2];
        sc_edge = state_ff.sc_sync[1] ^ state_ff.sc_sync[2];
        is_sub = state_ff.mode[`RSMC_OM_MSB:`RSMC_OM_LSB] == `RSMC_OM_STREAM_SUB;
        is_bpsk = state_ff.mode[`RSMC_OM_MSB:`RSMC_OM_LSB] == `RSMC_OM_STREAM_BPSK;
        scf = state_ff.opts[`RSMC_SCF_MSB:`RSMC_SCF_LSB];
        stx = state_ff.opts[`RSMC_STX_MSB:`RSMC_STX_LSB];
        scp_eff = state_ff.opts[`RSMC_SCP_MSB:`RSMC_SCP_LSB];
        // Sub-carrier mode has no single-period report, so 00b acts as two
        if (is_sub && scp_eff == 2'h0) begin
            scp_eff = 2'h1; // RULE_02
        end
        if (is_sub) begin
            sub_len = `RSMC_SUB_SC_BASE >> scf; // RULE_01 RULE_06
        end else if (scf == 2'h3) begin
            sub_len = `RSMC_BPSK_SC_MIN;
        end else begin
            sub_len = `RSMC_BPSK_SC_BASE >> scf; // RULE_07 RULE_11
        end
        per_len = 10'(sub_len) << scp_eff; // RULE_08
        tx_len = `RSMC_TX_BASE >> stx; // RULE_13
        // A shorter period written mid-count must not let the counter run to wrap
        per_end = car_tick && state_ff.per_cnt >= per_len - 10'h001;
        present = state_ff.edges >= DET_MIN;
        tx_go = tx_cmd_i | tx_cmd_crc_i;
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_state.car_sync = {state_ff.car_sync[1:0], carrier_i};
        nxt_state.sc_sync = {state_ff.sc_sync[1:0], subcarrier_i};
        nxt_state.rx_bit_vld = 1'b0;
        nxt_state.rx_flush = 1'b0;
        nxt_state.rx_start = 1'b0;
        nxt_state.rx_end = 1'b0;

        if (reg_wr_i && reg_addr_i == `RSMC_ADDR_MODE) begin
            nxt_state.mode = reg_wdata_i; // RULE_16
        end
        if (reg_wr_i && reg_addr_i == `RSMC_ADDR_OPTS) begin
            nxt_state.opts = reg_wdata_i;
        end
        case (reg_addr_i)
            `RSMC_ADDR_MODE: nxt_state.rdata = state_ff.mode;
            `RSMC_ADDR_OPTS: nxt_state.rdata = state_ff.opts;
            default: nxt_state.rdata = 8'h00;
        endcase

        // Receive timing advances only on carrier edges
        if (car_tick) begin
            nxt_state.per_cnt = per_end ? 10'h000 : state_ff.per_cnt + 10'h001; // RULE_17
            if (state_ff.sc_cnt >= sub_len - 7'h01) begin
                nxt_state.sc_cnt = 7'h00;
            end else begin
                nxt_state.sc_cnt = state_ff.sc_cnt + 7'h01;
            end
            if (state_ff.sc_cnt == (sub_len >> 2)) begin
                nxt_state.samp = state_ff.sc_sync[1];
            end
        end
        if (per_end) begin
            nxt_state.edges = 4'h0;
        end else if (sc_edge && state_ff.edges != 4'hF) begin
            nxt_state.edges = state_ff.edges + 4'h1;
        end

        // Receive is held off while transmitting or outside stream mode
        if (!(is_sub || is_bpsk) || state_ff.tx_st != rsmc_pkg::TX_IDLE) begin
            nxt_state.rx_st = rsmc_pkg::RX_HUNT;
            nxt_state.quiet = 4'h0;
            nxt_state.rx_flush = state_ff.rx_st == rsmc_pkg::RX_DATA;
        end else if (per_end) begin
            case (state_ff.rx_st)
                rsmc_pkg::RX_HUNT: begin
                    if (present) begin
                        nxt_state.rx_st = rsmc_pkg::RX_DATA; // RULE_03
                        nxt_state.rx_start = 1'b1;
                        nxt_state.rx_bit_vld = 1'b1;
                        nxt_state.rx_bit = is_sub;
                        nxt_state.ref_ph = state_ff.samp; // RULE_09
                        nxt_state.quiet = 4'h0;
                    end
                end
                rsmc_pkg::RX_DATA: begin
                    if (is_sub) begin
                        if (present) begin
                            nxt_state.quiet = 4'h0;
                        end else begin
                            nxt_state.quiet = state_ff.quiet + 4'h1;
                        end
                        if (!present && state_ff.quiet == `RSMC_QUIET_LIMIT) begin
                            nxt_state.rx_st = rsmc_pkg::RX_HUNT; // RULE_05
                            nxt_state.rx_end = 1'b1;
                            nxt_state.rx_flush = 1'b1; // RULE_18
                            nxt_state.quiet = 4'h0;
                        end else begin
                            nxt_state.rx_bit_vld = 1'b1;
                            nxt_state.rx_bit = present; // RULE_04
                        end
                    end else if (!present) begin
                        nxt_state.rx_st = rsmc_pkg::RX_HUNT; // RULE_10
                        nxt_state.rx_end = 1'b1;
                        nxt_state.rx_flush = 1'b1;
                    end else begin
                        nxt_state.rx_bit_vld = 1'b1;
                        nxt_state.rx_bit = state_ff.samp ^ state_ff.ref_ph; // RULE_09
                    end
                end
                default: nxt_state.rx_st = rsmc_pkg::RX_HUNT;
            endcase
        end

        case (state_ff.tx_st)
            rsmc_pkg::TX_IDLE: begin
                if (tx_go) begin
                    nxt_state.tx_st = rsmc_pkg::TX_LOAD; // RULE_14
                end
            end
            rsmc_pkg::TX_LOAD: begin
                if (tx_valid_i) begin
                    nxt_state.tx_sh = tx_byte_i;
                    nxt_state.tx_idx = 3'h0;
                    nxt_state.tx_cnt = 8'h00;
                    nxt_state.tx_st = rsmc_pkg::TX_SEND;
                end else begin
                    nxt_state.tx_st = rsmc_pkg::TX_IDLE;
                end
            end
            rsmc_pkg::TX_SEND: begin
                if (car_tick) begin
                    if (state_ff.tx_cnt >= tx_len - 8'h01) begin
                        nxt_state.tx_cnt = 8'h00; // RULE_13
                        nxt_state.tx_idx = state_ff.tx_idx + 3'h1;
                        if (state_ff.tx_idx == 3'h7) begin
                            nxt_state.tx_st = rsmc_pkg::TX_LOAD;
                        end
                    end else begin
                        nxt_state.tx_cnt = state_ff.tx_cnt + 8'h01;
                    end
                end
            end
            default: nxt_state.tx_st = rsmc_pkg::TX_IDLE;
        endcase
        // Modulator holds its level while the next byte is fetched
        if (nxt_state.tx_st == rsmc_pkg::TX_SEND) begin
            nxt_state.mod = nxt_state.tx_sh[nxt_state.tx_idx]; // RULE_12 RULE_15
        end else if (nxt_state.tx_st == rsmc_pkg::TX_IDLE) begin
            nxt_state.mod = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_ff <= '0;
            state_ff.mode <= `RSMC_MODE_RST;
            state_ff.opts <= `RSMC_OPTS_RST;
            state_ff.rx_st <= rsmc_pkg::RX_HUNT;
            state_ff.tx_st <= rsmc_pkg::TX_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    rsmc_packer u_packer (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .bit_vld_i(state_ff.rx_bit_vld),
        .bit_i(state_ff.rx_bit),
        .flush_i(state_ff.rx_flush),
        .byte_o(rx_byte_o),
        .nbits_o(rx_nbits_o),
        .push_o(rx_push_o)
    );

    assign reg_rdata_o = state_ff.rdata;
    assign tx_ready_o = state_ff.tx_st == rsmc_pkg::TX_LOAD;
    assign mod_o = state_ff.mod;
    assign tx_busy_o = state_ff.tx_st != rsmc_pkg::TX_IDLE;
    assign rx_start_o = state_ff.rx_start;
    assign rx_end_o = state_ff.rx_end;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    tx_idle_quiet_a: assert property (!tx_busy_o |-> !mod_o) // RULE_12
        else $error("Modulation while transmitter idle");
    tx_cmd_start_a: assert property (!tx_busy_o && !tx_go |=> !tx_busy_o) // RULE_14
        else $error("Transmit started without command");
    tx_bit_len_a: assert property (state_ff.tx_st == rsmc_pkg::TX_SEND |->
        state_ff.tx_cnt < tx_len) // RULE_13
        else $error("Tx bit period counter overran");
    rx_start_bit_a: assert property (rx_start_o |-> state_ff.rx_bit_vld
        && state_ff.rx_bit == is_sub) // RULE_03
        else $error("Start of receive without proper first bit");
    sub_end_quiet_a: assert property (rx_end_o && is_sub |->
        $past(state_ff.quiet) == `RSMC_QUIET_LIMIT) // RULE_05
        else $error("Sub-carrier end before nine empty periods");
    bpsk_end_a: assert property (is_bpsk && per_end && !present && !tx_busy_o
        && state_ff.rx_st == rsmc_pkg::RX_DATA |=> rx_end_o && state_ff.rx_flush) // RULE_10
        else $error("BPSK end not flagged with flush");
    sub_bit_val_a: assert property (is_sub && state_ff.rx_bit_vld |->
        state_ff.rx_bit == $past(present)) // RULE_04
        else $error("Sub-carrier bit does not match period content");
    car_count_a: assert property (!car_tick |=> $stable(state_ff.per_cnt)) // RULE_17
        else $error("Reporting counter moved without carrier edge");
    sc_range_a: assert property ((is_sub |-> sub_len >= 7'h08 && sub_len <= 7'h40)
        and (is_bpsk |-> sub_len >= 7'h04 && sub_len <= 7'h10)) // RULE_01 RULE_07
        else $error("Sub-carrier period out of range");

    sub_rx_c: cover property (is_sub && rx_start_o ##[1:1000] rx_end_o);
    bpsk_rx_c: cover property (is_bpsk && rx_start_o ##[1:1000] rx_end_o);
    tx_byte_c: cover property (tx_go ##[1:300] tx_ready_o && tx_valid_i);

endmodule : rsmc_codec

// *** logic/rsmc_packer.sv ***
/*
 * Packs received stream bits into bytes, first bit in the least significant
 * position, and commits a partial byte on flush.
 * Assumes bit_vld_i and flush_i never coincide and come from the same clock.
 */
`timescale 1ns/1ps
module rsmc_packer (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic bit_vld_i,
    input wire logic bit_i,
    input wire logic flush_i,
    output logic [7:0] byte_o,
    output logic [3:0] nbits_o,
    output logic push_o
);
    rsmc_pkg::rsmc_pack_t state_ff;
    rsmc_pkg::rsmc_pack_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.push = 1'b0;
        if (bit_vld_i) begin
            nxt_state.sh[state_ff.n[2:0]] = bit_i; // RULE_15
            nxt_state.n = state_ff.n + 4'h1;
            if (state_ff.n == 4'h7) begin
                nxt_state.data = nxt_state.sh;
                nxt_state.nbits = 4'h8;
                nxt_state.push = 1'b1;
                nxt_state.n = 4'h0;
                nxt_state.sh = 8'h00;
            end
        end else if (flush_i && state_ff.n != 4'h0) begin
            nxt_state.data = state_ff.sh; // RULE_18
            nxt_state.nbits = state_ff.n;
            nxt_state.push = 1'b1;
            nxt_state.n = 4'h0;
            nxt_state.sh = 8'h00;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign byte_o = state_ff.data;
    assign nbits_o = state_ff.nbits;
    assign push_o = state_ff.push;

endmodule : rsmc_packer

// *** logic/rsmc_pkg.sv ***
/*
 * Types of the stream-mode codec: state enums and the packed state records.
 * Assumes nothing of its surroundings.
 */
package rsmc_pkg;

    typedef enum logic [1:0] {
        RX_HUNT = 2'h1,
        RX_DATA = 2'h2
    } rsmc_rx_st_t;

    typedef enum logic [2:0] {
        TX_IDLE = 3'h1,
        TX_LOAD = 3'h2,
        TX_SEND = 3'h4
    } rsmc_tx_st_t;

    typedef struct packed {
        logic [2:0] car_sync;
        logic [2:0] sc_sync;
        logic [7:0] mode;
        logic [7:0] opts;
        logic [7:0] rdata;
        rsmc_rx_st_t rx_st;
        logic [9:0] per_cnt;
        logic [6:0] sc_cnt;
        logic [3:0] edges;
        logic [3:0] quiet;
        logic ref_ph;
        logic samp;
        logic rx_bit_vld;
        logic rx_bit;
        logic rx_flush;
        logic rx_start;
        logic rx_end;
        rsmc_tx_st_t tx_st;
        logic [7:0] tx_sh;
        logic [2:0] tx_idx;
        logic [7:0] tx_cnt;
        logic mod;
    } rsmc_state_t;

    typedef struct packed {
        logic [7:0] sh;
        logic [3:0] n;
        logic [7:0] data;
        logic [3:0] nbits;
        logic push;
    } rsmc_pack_t;

endpackage : rsmc_pkg

// *** logic/rsmc_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the
 * stream-mode codec. Assumes a 6-bit register address from the serial port.
 */
`ifndef RSMC_REGS_SVH
`define RSMC_REGS_SVH

`define RSMC_ADDR_MODE 6'h03
`define RSMC_ADDR_OPTS 6'h08

`define RSMC_MODE_RST 8'h00
`define RSMC_OPTS_RST 8'h00

// Operating-mode field inside operating_mode_select
`define RSMC_OM_MSB 6
`define RSMC_OM_LSB 3
`define RSMC_OM_STREAM_SUB 4'hE
`define RSMC_OM_STREAM_BPSK 4'hF

// Fields of stream_options
`define RSMC_SCF_MSB 6
`define RSMC_SCF_LSB 5
`define RSMC_SCP_MSB 4
`define RSMC_SCP_LSB 3
`define RSMC_STX_MSB 2
`define RSMC_STX_LSB 0

// Timing in carrier cycles; the quiet limit in reporting periods
`define RSMC_SUB_SC_BASE 7'h40
`define RSMC_BPSK_SC_BASE 7'h10
`define RSMC_BPSK_SC_MIN 7'h04
`define RSMC_TX_BASE 8'h80
`define RSMC_QUIET_LIMIT 4'h8

`endif

// *** sim/rsmc_tag_model.sv ***
/*
 * Contactless tag model: makes the carrier and a digitised sub-carrier whose
 * presence and phase the bench commands.
 * Assumes the bench changes its commands between clock edges.
 */
`timescale 1ns/1ps
module rsmc_tag_model (
    input wire logic sys_clk_i,
    input wire logic [4:0] half_i,
    input wire logic sc_on_i,
    input wire logic sc_inv_i,
    output logic carrier_o,
    output logic subcarrier_o
);
    logic [1:0] div_ff = 2'h0;
    logic [4:0] half_cnt_ff = 5'h00;
    logic sq_ff = 1'b0;

    // Sub-carrier half period counted in carrier cycles, as a real tag load does
    always @(posedge sys_clk_i) begin
        div_ff <= div_ff + 2'h1;
        if (div_ff == 2'h3) begin
            if (half_cnt_ff + 5'h01 >= half_i) begin
                half_cnt_ff <= 5'h00;
                sq_ff <= ~sq_ff;
            end else begin
                half_cnt_ff <= half_cnt_ff + 5'h01;
            end
        end
    end

    assign carrier_o = div_ff[1];
    // No modulation leaves the demodulator output flat, so no edges reach the codec
    assign subcarrier_o = sc_on_i & (sq_ff ^ sc_inv_i);
endmodule : rsmc_tag_model

// *** sim/tb.sv ***
/*
 * Self-checking bench of the stream-mode codec: registers, both receive
 * variants and transmit, with a tag model on the RF side.
 * Assumes the carrier at a quarter of the 50 MHz system clock.
 */
`timescale 1ns/1ps
`include "rsmc_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic [5:0] reg_addr_i = 6'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic tx_cmd_i = 1'b0;
    logic tx_cmd_crc_i = 1'b0;
    logic [7:0] tx_byte_i = 8'h00;
    logic tx_valid_i = 1'b0;
    logic sc_on = 1'b0;
    logic sc_inv = 1'b0;
    logic [4:0] sc_half = 5'h04;
    logic carrier, subcarrier;
    logic [7:0] reg_rdata_o, rx_byte_o;
    logic [3:0] rx_nbits_o;
    logic tx_ready_o, mod_o, tx_busy_o, rx_push_o, rx_start_o, rx_end_o;
    int failures = 0;
    int n_checks = 0;
    int n_end = 0;
    logic [31:0] rng = 32'h343ECDF1;
    logic [11:0] push_q[$];

    always #10 sys_clk_i = ~sys_clk_i;

    rsmc_tag_model TAG (.sys_clk_i(sys_clk_i), .half_i(sc_half), .sc_on_i(sc_on),
        .sc_inv_i(sc_inv), .carrier_o(carrier), .subcarrier_o(subcarrier));

    rsmc_codec DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .carrier_i(carrier), .subcarrier_i(subcarrier), .tx_cmd_i(tx_cmd_i),
        .tx_cmd_crc_i(tx_cmd_crc_i), .tx_byte_i(tx_byte_i), .tx_valid_i(tx_valid_i),
        .tx_ready_o(tx_ready_o), .mod_o(mod_o), .tx_busy_o(tx_busy_o),
        .rx_byte_o(rx_byte_o), .rx_nbits_o(rx_nbits_o), .rx_push_o(rx_push_o),
        .rx_start_o(rx_start_o), .rx_end_o(rx_end_o));

    always @(posedge sys_clk_i) begin
        if (rx_push_o) push_q.push_back({rx_nbits_o, rx_byte_o});
        if (rx_end_o) n_end++;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic wrap_up();
        if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge sys_clk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge sys_clk_i);
        reg_wr_i = 1'b0;
    endtask : wr

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        @(negedge sys_clk_i);
        reg_addr_i = a;
        repeat (2) @(negedge sys_clk_i);
        `CHK("reg_rdata_o", e, reg_rdata_o)
    endtask : rd_chk

    // Bits are changed just after each reported period, so a late edge never counts twice
    task automatic rx_run(input logic bpsk, input logic [1:0] scf, input logic [1:0] scp,
            input logic [4:0] half, input int per, input int nb);
        logic [11:0] exp_q[$];
        logic [15:0] bits;
        logic [7:0] acc;
        int n;
        int k;
        bits = rng[15:0];
        rng = xs(rng);
        // Breaks up long quiet runs so that only the final gap ends reception
        bits[4] = 1'b1;
        bits[nb - 1] = 1'b1;
        acc = 8'h00;
        n = 0;
        wr(`RSMC_ADDR_MODE, {1'b0, bpsk ? `RSMC_OM_STREAM_BPSK : `RSMC_OM_STREAM_SUB, 3'h0});
        wr(`RSMC_ADDR_OPTS, {1'b0, scf, scp, 3'h0});
        sc_half = half;
        push_q = {};
        n_end = 0;
        sc_inv = 1'b0;
        sc_on = 1'b1;
        for (k = 0; k < 8 * per && !rx_start_o; k++) @(negedge sys_clk_i);
        `CHK("rx_start_o", 1'b1, rx_start_o)
        for (k = 0; k < nb; k++) begin
            if (bpsk) sc_inv = bits[k];
            else sc_on = bits[k];
            repeat (per) @(negedge sys_clk_i);
        end
        sc_on = 1'b0;
        repeat (bpsk ? 2 : 8 * per) @(negedge sys_clk_i);
        `CHK("rx_end_o early", 0, n_end)
        repeat (per + 8) @(negedge sys_clk_i);
        `CHK("rx_end_o", 1, n_end)
        for (k = 0; k < 1 + nb + (bpsk ? 0 : 8); k++) begin
            acc[n] = (k == 0) ? !bpsk : (k <= nb) ? bits[k - 1] : 1'b0;
            n++;
            if (n == 8 || k == nb + (bpsk ? 0 : 8)) begin
                exp_q.push_back({4'(n), acc});
                acc = 8'h00;
                n = 0;
            end
        end
        `CHK("rx push count", exp_q.size(), push_q.size())
        for (k = 0; k < exp_q.size() && k < push_q.size(); k++)
            `CHK("rx nbits and byte", exp_q[k], push_q[k])
    endtask : rx_run

    task automatic tx_run(input logic [2:0] stx, input logic crc);
        logic [7:0] d[2];
        int t;
        int j;
        int k;
        t = (128 >> stx) * 4;
        d[0] = rng[7:0];
        d[1] = rng[15:8];
        rng = xs(rng);
        wr(`RSMC_ADDR_OPTS, {5'h00, stx});
        `CHK("mod_o idle", 1'b0, mod_o)
        tx_byte_i = d[0];
        tx_valid_i = 1'b1;
        tx_cmd_i = !crc;
        tx_cmd_crc_i = crc;
        @(negedge sys_clk_i);
        tx_cmd_i = 1'b0;
        tx_cmd_crc_i = 1'b0;
        for (j = 0; j < 2; j++) begin
            for (k = 0; k < t && !tx_ready_o; k++) @(negedge sys_clk_i);
            `CHK("tx_ready_o", 1'b1, tx_ready_o)
            @(negedge sys_clk_i);
            tx_byte_i = d[1];
            tx_valid_i = (j == 0);
            for (k = 0; k < 8; k++) begin
                repeat (t / 2) @(negedge sys_clk_i);
                `CHK("mod_o", d[j][k], mod_o)
                if (k < 7) repeat (t / 2) @(negedge sys_clk_i);
            end
        end
        for (k = 0; k < t && tx_busy_o; k++) @(negedge sys_clk_i);
        `CHK("tx_busy_o", 1'b0, tx_busy_o)
        `CHK("mod_o end", 1'b0, mod_o)
    endtask : tx_run

    initial begin
        int i;
        logic [7:0] v;
        repeat (4) @(negedge sys_clk_i);
        srst_i = 1'b0;
        rd_chk(`RSMC_ADDR_MODE, `RSMC_MODE_RST);
        rd_chk(`RSMC_ADDR_OPTS, `RSMC_OPTS_RST);
        for (i = 0; i < 4; i++) begin
            v = rng[7:0];
            rng = xs(rng);
            wr(i[0] ? `RSMC_ADDR_MODE : `RSMC_ADDR_OPTS, v);
            rd_chk(i[0] ? `RSMC_ADDR_MODE : `RSMC_ADDR_OPTS, v);
            wr(6'h04, v);
            rd_chk(6'h04, 8'h00);
        end
        rx_run(1'b0, 2'h3, 2'h1, 5'h04, 64, 10);
        rx_run(1'b0, 2'h1, 2'h2, 5'h10, 512, 10);
        rx_run(1'b1, 2'h1, 2'h1, 5'h04, 64, 10);
        tx_run(3'h0, 1'b0);
        tx_run(3'h3, 1'b1);
        wrap_up();
    end

    initial begin
        #1_500_000;
        failures++;
        wrap_up();
    end
endmodule : tb
